/* mtg_top.sv */
// Memory traffic generator with write, read-back and compare
`include "mtg_regs.svh"
module mtg_top #(
    parameter int AW = `MTG_ADDR_W,
    parameter int SW = `MTG_SIZE_W,
    parameter int DW = `MTG_DATA_W,
    parameter int SEQ_OPS = 8,
    parameter int RAND_OPS = 8,
    parameter int MIX_OPS = 8,
    parameter int BLOCK_N = 4,
    parameter logic [23:0] RAND_LO = 24'h000100,
    parameter logic [23:0] RAND_SPAN = 24'h000400,
    parameter logic [7:0] MIX_SEQ_PCT = 8'h32,
    parameter logic [2:0] BURST_MIN_SEQ = 3'h1,
    parameter logic [2:0] BURST_MAX_SEQ = 3'h4,
    parameter logic [2:0] BURST_MIN_RAND = 3'h1,
    parameter logic [2:0] BURST_MAX_RAND = 3'h2,
    parameter logic [2:0] BURST_MIN_MIX = 3'h1,
    parameter logic [2:0] BURST_MAX_MIX = 3'h3,
    parameter logic [2:0] BYTE_SHIFT = 3'h3,
    parameter int TIMEOUT_CYC = `MTG_TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [AW-1:0] seq_start_addr,
    input wire logic byte_addr_en,
    input wire logic avl_ready,
    output logic avl_write_req,
    output logic avl_read_req,
    output logic [AW-1:0] avl_addr,
    output logic [SW-1:0] avl_size,
    output logic [DW-1:0] avl_wdata,
    input wire logic [DW-1:0] avl_rdata,
    input wire logic avl_rdata_valid,
    output logic [DW-1:0] pnf_per_bit,
    output logic [DW-1:0] pnf_per_bit_persist,
    output logic pass,
    output logic fail,
    output logic test_complete
);
    localparam int NMAX = 16;
    // Each random-address op owns an eight-word slot, so one group never overwrites itself; costs address spread
    localparam logic [23:0] RAND_SLOTS = (RAND_SPAN[23:7] == 17'h00000) ? 24'h000001 : {7'h00, RAND_SPAN[23:7]};
    mtg_pkg::mtg_top_type top_q;
    mtg_pkg::mtg_sub_type sub_q;
    mtg_pkg::mtg_phase_type ph_q;
    logic [31:0] lfsr_q;
    logic [15:0] ops_q;
    logic [4:0] nidx_q;
    logic [4:0] rdidx_q;
    logic [SW-1:0] beat_q;
    logic [AW-1:0] seq_addr_q;
    logic [AW-1:0] op_addr [NMAX];
    logic [SW-1:0] op_size [NMAX];
    logic [31:0] seed_q [NMAX];
    logic [15:0] rbeat_q;
    logic [15:0] pend_q;
    logic mism_q;
    logic [31:0] tmo_q;
    logic [15:0] exp_cnt_q;
    logic [DW-1:0] exp_data;
    logic [4:0] nops;
    logic [15:0] sub_ops;
    logic [2:0] bmin;
    logic [2:0] bmax;
    logic [2:0] burst;
    logic use_seq;
    logic [AW-1:0] rand_addr;
    logic [AW-1:0] gen_addr;
    logic [AW-1:0] seq_cur;
    logic done_all;
    logic accept;
    logic [DW-1:0] cmp;

    // Data pattern from operation seed and beat, so expected data needs no storage of words
    function automatic logic [DW-1:0] pattern(input logic [31:0] s, input logic [15:0] b);
        logic [31:0] x;
        x = s ^ {b, b};
        pattern = {x[7:0], x, ~x};
    endfunction : pattern

    assign nops = (top_q == mtg_pkg::MTG_BLOCK) ? 5'(BLOCK_N) : 5'h01;
    always_comb begin
        sub_ops = 16'(SEQ_OPS);
        bmin = BURST_MIN_SEQ;
        bmax = BURST_MAX_SEQ;
        unique case (sub_q)
            mtg_pkg::MTG_SEQ: begin
                sub_ops = 16'(SEQ_OPS);
            end
            mtg_pkg::MTG_RAND: begin
                sub_ops = 16'(RAND_OPS);
                bmin = BURST_MIN_RAND;
                bmax = BURST_MAX_RAND;
            end
            mtg_pkg::MTG_MIX: begin
                sub_ops = 16'(MIX_OPS);
                bmin = BURST_MIN_MIX;
                bmax = BURST_MAX_MIX;
            end
        endcase
    end
    // Burst drawn within the substate's range
    assign burst = bmin + 3'(lfsr_q[7:0] % 8'(bmax - bmin + 3'h1));
    assign use_seq = (sub_q == mtg_pkg::MTG_SEQ) ||
        ((sub_q == mtg_pkg::MTG_MIX) && (lfsr_q[15:8] % 8'h64 < MIX_SEQ_PCT));
    assign rand_addr = RAND_LO + AW'({lfsr_q[31:8] % RAND_SLOTS, nidx_q[3:0], 3'h0});
    assign seq_cur = (sub_q == mtg_pkg::MTG_SEQ && ops_q == 16'h0000 && nidx_q == 5'h00) ? seq_start_addr
        : seq_addr_q;
    assign gen_addr = use_seq ? seq_cur : rand_addr;
    assign accept = avl_ready && (avl_write_req || avl_read_req);
    assign done_all = (pend_q == 16'h0000);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lfsr_q <= `MTG_LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        end
    end

    // Sequencer: state, substate and phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            top_q <= mtg_pkg::MTG_INDIV;
            sub_q <= mtg_pkg::MTG_SEQ;
            ph_q <= mtg_pkg::MTG_PH_NEXT;
            ops_q <= 16'h0000;
            nidx_q <= 5'h00;
            beat_q <= '0;
            seq_addr_q <= '0;
            avl_write_req <= 1'b0;
            avl_read_req <= 1'b0;
            avl_addr <= '0;
            avl_size <= '0;
            avl_wdata <= '0;
            for (int i = 0; i < NMAX; i++) begin
                op_addr[i] <= '0;
                op_size[i] <= '0;
                seed_q[i] <= '0;
            end
        end else if (top_q == mtg_pkg::MTG_INDIV || top_q == mtg_pkg::MTG_BLOCK) begin
            unique case (ph_q)
                mtg_pkg::MTG_PH_NEXT: begin
                    if (ops_q >= sub_ops) begin
                        ops_q <= 16'h0000;
                        unique case (sub_q)
                            mtg_pkg::MTG_SEQ: sub_q <= mtg_pkg::MTG_RAND;
                            mtg_pkg::MTG_RAND: sub_q <= mtg_pkg::MTG_MIX;
                            mtg_pkg::MTG_MIX: begin
                                sub_q <= mtg_pkg::MTG_SEQ;
                                if (top_q == mtg_pkg::MTG_INDIV) begin
                                    top_q <= mtg_pkg::MTG_BLOCK;
                                end else begin
                                    // Every group was already drained and compared clean in the wait phase
                                    top_q <= mtg_pkg::MTG_PASS;
                                end
                            end
                        endcase
                    end else begin
                        // Plan one write op of the group; the read group reuses it exactly
                        op_addr[nidx_q[3:0]] <= gen_addr;
                        op_size[nidx_q[3:0]] <= burst;
                        seed_q[nidx_q[3:0]] <= lfsr_q;
                        if (use_seq) begin
                            seq_addr_q <= seq_cur + AW'(burst);
                        end
                        avl_write_req <= 1'b1;
                        avl_addr <= byte_addr_en ? (gen_addr << BYTE_SHIFT) : gen_addr;
                        avl_size <= burst;
                        avl_wdata <= pattern(lfsr_q, 16'h0000);
                        beat_q <= '0;
                        ph_q <= mtg_pkg::MTG_PH_WR;
                    end
                end
                mtg_pkg::MTG_PH_WR: begin
                    if (accept) begin
                        if (beat_q + 3'h1 < op_size[nidx_q[3:0]]) begin
                            beat_q <= beat_q + 3'h1;
                            avl_wdata <= pattern(seed_q[nidx_q[3:0]], 16'(beat_q + 3'h1));
                        end else if (nidx_q + 5'h01 < nops) begin
                            avl_write_req <= 1'b0;
                            nidx_q <= nidx_q + 5'h01;
                            ph_q <= mtg_pkg::MTG_PH_NEXT;
                        end else begin
                            // Writes done: read back the same group
                            avl_write_req <= 1'b0;
                            avl_read_req <= 1'b1;
                            nidx_q <= 5'h00;
                            avl_addr <= byte_addr_en ? (op_addr[0] << BYTE_SHIFT) : op_addr[0];
                            avl_size <= op_size[0];
                            ph_q <= mtg_pkg::MTG_PH_RD;
                        end
                    end
                end
                mtg_pkg::MTG_PH_RD: begin
                    if (accept) begin
                        if (nidx_q + 5'h01 < nops) begin
                            nidx_q <= nidx_q + 5'h01;
                            avl_addr <= byte_addr_en ? (op_addr[nidx_q[3:0] + 4'h1] << BYTE_SHIFT)
                                : op_addr[nidx_q[3:0] + 4'h1];
                            avl_size <= op_size[nidx_q[3:0] + 4'h1];
                        end else begin
                            avl_read_req <= 1'b0;
                            ph_q <= mtg_pkg::MTG_PH_WAIT;
                        end
                    end
                end
                mtg_pkg::MTG_PH_WAIT: begin
                    // Next group only after all reads of this one compared
                    if (done_all) begin
                        if (mism_q) begin
                            top_q <= mtg_pkg::MTG_FAIL;
                        end else begin
                            nidx_q <= 5'h00;
                            ops_q <= ops_q + 16'h0001;
                            ph_q <= mtg_pkg::MTG_PH_NEXT;
                        end
                    end
                end
            endcase
            if (tmo_q >= 32'(TIMEOUT_CYC)) begin
                top_q <= mtg_pkg::MTG_FAIL;
                avl_write_req <= 1'b0;
                avl_read_req <= 1'b0;
            end
        end
    end

    // Outstanding beats; counts up on read issue, down on valid data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_q <= 16'h0000;
        end else begin
            pend_q <= pend_q + ((avl_read_req && avl_ready) ? 16'(avl_size) : 16'h0000)
                - (avl_rdata_valid ? 16'h0001 : 16'h0000);
        end
    end

    // Read comparison walks the same group in order
    assign exp_data = pattern(seed_q[rdidx_q[3:0]], exp_cnt_q);
    assign cmp = ~(avl_rdata ^ exp_data);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdidx_q <= 5'h00;
            rbeat_q <= 16'h0000;
            exp_cnt_q <= 16'h0000;
            mism_q <= 1'b0;
            pnf_per_bit <= '1;
            pnf_per_bit_persist <= '1;
        end else if (avl_rdata_valid) begin
            pnf_per_bit <= cmp;
            pnf_per_bit_persist <= pnf_per_bit_persist & cmp;
            if (cmp != '1) begin
                mism_q <= 1'b1;
            end
            if (exp_cnt_q + 16'h0001 < 16'(op_size[rdidx_q[3:0]])) begin
                exp_cnt_q <= exp_cnt_q + 16'h0001;
            end else begin
                exp_cnt_q <= 16'h0000;
                rdidx_q <= (rdidx_q + 5'h01 < nops) ? rdidx_q + 5'h01 : 5'h00;
            end
            rbeat_q <= rbeat_q + 16'h0001;
        end
    end

    // Timeout on the bus clock; restarts on any bus progress
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tmo_q <= 32'h0;
        end else if (accept || avl_rdata_valid || top_q == mtg_pkg::MTG_PASS || top_q == mtg_pkg::MTG_FAIL) begin
            tmo_q <= 32'h0;
        end else begin
            tmo_q <= tmo_q + 32'h1;
        end
    end

    // Terminal states hold until reset
    assign pass = (top_q == mtg_pkg::MTG_PASS);
    assign fail = (top_q == mtg_pkg::MTG_FAIL);
    assign test_complete = pass || fail;

    chk_req_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (avl_write_req && !avl_ready && !fail && tmo_q < 32'(TIMEOUT_CYC))
        |=> (avl_write_req && $stable(avl_addr) && $stable(avl_wdata)))
        else $error("write request dropped before ready");
    chk_rd_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (avl_read_req && !avl_ready && !fail && tmo_q < 32'(TIMEOUT_CYC))
        |=> (avl_read_req && $stable(avl_addr) && $stable(avl_size)))
        else $error("read request dropped before ready");
    chk_no_both_req: assert property (@(posedge ref_clk) disable iff (rst)
        !(avl_write_req && avl_read_req))
        else $error("read and write requested together");
    chk_pass_clean: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pass) |-> (pnf_per_bit_persist == '1) && (pend_q == 16'h0000))
        else $error("pass with mismatch or pending reads");
    chk_fail_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        fail |=> fail && !pass)
        else $error("fail state left without reset");
    chk_mism_fail: assert property (@(posedge ref_clk) disable iff (rst)
        (mism_q && ph_q == mtg_pkg::MTG_PH_WAIT && done_all && !fail) |=> fail)
        else $error("mismatch did not lead to fail");
    chk_done_flag: assert property (@(posedge ref_clk) disable iff (rst)
        test_complete |=> test_complete && $stable(pass))
        else $error("run done dropped before reset");
    chk_timeout_fail: assert property (@(posedge ref_clk) disable iff (rst)
        (tmo_q >= 32'(TIMEOUT_CYC) && !pass) |=> fail)
        else $error("timeout did not fail");
    chk_burst_range: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(avl_write_req) |-> (avl_size >= bmin && avl_size <= bmax))
        else $error("burst outside range");
    chk_no_req_end: assert property (@(posedge ref_clk) disable iff (rst)
        (pass || fail) |=> !avl_write_req && !avl_read_req)
        else $error("request in terminal state");
endmodule : mtg_top

/* mtg_regs.svh */
// Constants for the memory traffic generator self-test block
`ifndef MTG_REGS_SVH
`define MTG_REGS_SVH
`define MTG_ADDR_W 24
`define MTG_SIZE_W 3
`define MTG_DATA_W 72
`define MTG_LFSR_SEED 32'h1234abcd
`define MTG_TIMEOUT_CYC 100000
`endif

/* mtg_pkg.sv */
// Types for the memory traffic generator
package mtg_pkg;
    typedef enum logic [3:0] {
        MTG_INDIV = 4'h1,
        MTG_BLOCK = 4'h2,
        MTG_PASS = 4'h4,
        MTG_FAIL = 4'h8
    } mtg_top_type;
    typedef enum logic [2:0] {
        MTG_SEQ = 3'h1,
        MTG_RAND = 3'h2,
        MTG_MIX = 3'h4
    } mtg_sub_type;
    typedef enum logic [3:0] {
        MTG_PH_WR = 4'h1,
        MTG_PH_RD = 4'h2,
        MTG_PH_WAIT = 4'h4,
        MTG_PH_NEXT = 4'h8
    } mtg_phase_type;
endpackage : mtg_pkg

/* mtg_mem_model.sv */
// Behavioural memory slave answering the traffic generator
module mtg_mem_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic stall,
    input wire logic corrupt,
    input wire logic avl_write_req,
    input wire logic avl_read_req,
    input wire logic [23:0] avl_addr,
    input wire logic [2:0] avl_size,
    input wire logic [71:0] avl_wdata,
    output logic avl_ready,
    output logic [71:0] avl_rdata,
    output logic avl_rdata_valid,
    output int pending,
    output int bad_rd,
    output int wr_bursts,
    output int rd_bursts
);
    logic [71:0] mem [int];
    logic [71:0] rq [$];
    logic [71:0] last;
    logic hit;
    int wbeat;
    int cyc;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avl_ready <= 1'b0;
            avl_rdata_valid <= 1'b0;
            avl_rdata <= 72'h0;
            rq.delete();
            last = 72'h0;
            hit = 1'b0;
            wbeat = 0;
            cyc = 0;
            pending = 0;
            bad_rd = 0;
            wr_bursts = 0;
            rd_bursts = 0;
        end else begin
            cyc = cyc + 1;
            // Slow mode grants one cycle in four so a request can be held waiting for ready
            avl_ready <= !stall && (!slow || cyc[1:0] == 2'h0);
            if (avl_write_req && avl_ready) begin
                if (wbeat == 0) wr_bursts = wr_bursts + 1;
                mem[int'(avl_addr) + wbeat] = avl_wdata;
                wbeat = (wbeat + 1 >= int'(avl_size)) ? 0 : wbeat + 1;
            end
            if (avl_read_req && avl_ready) begin
                rd_bursts = rd_bursts + 1;
                for (int k = 0; k < int'(avl_size); k++) begin
                    if (!mem.exists(int'(avl_addr) + k)) bad_rd = bad_rd + 1;
                    rq.push_back(mem.exists(int'(avl_addr) + k) ? mem[int'(avl_addr) + k] : 72'h0);
                end
            end
            if (rq.size() > 0 && (!slow || cyc[0])) begin
                avl_rdata_valid <= 1'b1;
                last = rq.pop_front() ^ {71'h0, corrupt && !hit};
                hit = hit | corrupt;
                avl_rdata <= last;
            end else begin
                avl_rdata_valid <= 1'b0;
                // Idle bus shows the inverse so stale data cannot pass as a match
                avl_rdata <= ~last;
            end
            pending = rq.size();
        end
    end
endmodule : mtg_mem_model

/* mtg_top_test.sv */
// Self-checking bench for the memory traffic generator
module mtg_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TO = 200;
    localparam int OPS = 3;
    localparam int BN = 3;
    localparam logic [23:0] START = 24'h001000;
    logic ref_clk, rst, byte_addr_en, slow, stall, corrupt;
    logic [23:0] seq_start_addr, avl_addr, first_addr, p_addr;
    logic avl_ready, avl_write_req, avl_read_req, avl_rdata_valid, pass, fail, test_complete;
    logic [2:0] avl_size, p_size;
    logic [71:0] avl_wdata, avl_rdata, pnf_per_bit, pnf_per_bit_persist, p_wdata;
    logic seen_first, prev_wr, prev_fail, p_wr, p_rd, p_rdy, pnf_low;
    int pending, bad_rd, wr_bursts, rd_bursts;
    int miscompares = 0;
    int samples_checked = 0;
    int tick = 0;
    int t0, done_at, out_range, unstable, pend_at_fail;
    mtg_top #(.SEQ_OPS(OPS), .RAND_OPS(OPS), .MIX_OPS(OPS), .BLOCK_N(BN), .TIMEOUT_CYC(TO)) uut (
        .ref_clk(ref_clk), .rst(rst), .seq_start_addr(seq_start_addr), .byte_addr_en(byte_addr_en),
        .avl_ready(avl_ready), .avl_write_req(avl_write_req), .avl_read_req(avl_read_req),
        .avl_addr(avl_addr), .avl_size(avl_size), .avl_wdata(avl_wdata), .avl_rdata(avl_rdata),
        .avl_rdata_valid(avl_rdata_valid), .pnf_per_bit(pnf_per_bit),
        .pnf_per_bit_persist(pnf_per_bit_persist), .pass(pass), .fail(fail), .test_complete(test_complete));
    mtg_mem_model mem (
        .ref_clk(ref_clk), .rst(rst), .slow(slow), .stall(stall), .corrupt(corrupt),
        .avl_write_req(avl_write_req), .avl_read_req(avl_read_req), .avl_addr(avl_addr),
        .avl_size(avl_size), .avl_wdata(avl_wdata), .avl_ready(avl_ready), .avl_rdata(avl_rdata),
        .avl_rdata_valid(avl_rdata_valid), .pending(pending), .bad_rd(bad_rd),
        .wr_bursts(wr_bursts), .rd_bursts(rd_bursts));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // Monitors sample on the falling edge, where everything launched at the rising edge has settled
    always @(negedge ref_clk) begin
        tick = tick + 1;
        if (tick > 90000) begin
            miscompares++;
            complete_run();
        end
        if (!rst) begin
            if (avl_write_req && !prev_wr) begin
                if (!seen_first) first_addr = avl_addr;
                seen_first = 1'b1;
                if (!byte_addr_en && !(avl_addr >= START && avl_addr < START + 24'h100)
                    && !(avl_addr >= 24'h000100 && avl_addr < 24'h000500)) out_range++;
            end
            if ((p_wr || p_rd) && !p_rdy && ({avl_write_req, avl_read_req} !== {p_wr, p_rd}
                || avl_addr !== p_addr || avl_size !== p_size || (p_wr && avl_wdata !== p_wdata))) unstable++;
            if (fail && !prev_fail) pend_at_fail = pending;
            if (pnf_per_bit[0] === 1'b0) pnf_low = 1'b1;
        end
        prev_wr = avl_write_req;
        prev_fail = fail;
        {p_wr, p_rd, p_rdy, p_addr, p_size, p_wdata} = {avl_write_req, avl_read_req, avl_ready, avl_addr, avl_size, avl_wdata};
    end
    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_vec(input string what, input logic [71:0] exp, input logic [71:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_vec
    task automatic check_cnt(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            miscompares++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt
    // One complete run: reset for five cycles, then wait for the generator to finish
    task automatic run(input logic s, input logic st, input logic c, input logic b);
        int n;
        @(posedge ref_clk);
        rst <= 1'b1;
        slow <= s;
        stall <= st;
        corrupt <= c;
        byte_addr_en <= b;
        repeat (5) @(posedge ref_clk);
        seen_first = 1'b0;
        out_range = 0;
        unstable = 0;
        pend_at_fail = -1;
        pnf_low = 1'b0;
        check_vec("persist_in_reset", {72{1'b1}}, pnf_per_bit_persist);
        rst <= 1'b0;
        t0 = tick;
        n = 0;
        while (test_complete !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        done_at = tick - t0;
        if (n >= 20000) check_bit("test_complete_seen", 1'b1, test_complete);
        repeat (3) @(posedge ref_clk);
    endtask : run
    initial begin
        rst = 1'b1;
        slow = 1'b0;
        stall = 1'b0;
        corrupt = 1'b0;
        byte_addr_en = 1'b0;
        seq_start_addr = START;
        run(1'b0, 1'b1, 1'b0, 1'b0);
        check_bit("fail_on_timeout", 1'b1, fail);
        check_bit("pass_on_timeout", 1'b0, pass);
        check_cnt("timeout_not_early", 1, int'(done_at >= TO));
        check_cnt("timeout_not_late", 1, int'(done_at <= TO + 60));
        run(1'b0, 1'b0, 1'b0, 1'b0);
        check_bit("pass_after_reset", 1'b1, pass);
        check_bit("fail_clean", 1'b0, fail);
        check_bit("complete_clean", 1'b1, test_complete);
        check_vec("persist_clean", {72{1'b1}}, pnf_per_bit_persist);
        check_vec("first_word_addr", {48'h0, START}, {48'h0, first_addr});
        check_cnt("addr_out_of_range", 0, out_range);
        check_cnt("write_read_balance", wr_bursts, rd_bursts);
        check_cnt("write_bursts", 3 * OPS + 3 * OPS * BN, wr_bursts);
        check_vec("last_beat_clean", {72{1'b1}}, pnf_per_bit);
        check_bit("pnf_steady_clean", 1'b0, pnf_low);
        check_cnt("reads_of_unwritten", 0, bad_rd);
        check_cnt("request_unstable", 0, unstable);
        run(1'b1, 1'b0, 1'b0, 1'b1);
        check_bit("pass_slow_slave", 1'b1, pass);
        check_vec("first_byte_addr", {48'h0, START << 3}, {48'h0, first_addr});
        check_cnt("request_unstable_slow", 0, unstable);
        check_cnt("reads_of_unwritten_slow", 0, bad_rd);
        run(1'b0, 1'b0, 1'b1, 1'b0);
        check_bit("fail_on_mismatch", 1'b1, fail);
        check_bit("pass_on_mismatch", 1'b0, pass);
        check_bit("persist_bit0", 1'b0, pnf_per_bit_persist[0]);
        check_bit("pnf_bit0_dropped", 1'b1, pnf_low);
        check_cnt("reads_pending_at_fail", 0, pend_at_fail);
        complete_run();
    end
endmodule : mtg_top_test
